//--- rtl/ssh_suspend_smi.sv
// Suspend request/acknowledge sequencer, management-interrupt entry
// and status packet source. Assumes all inputs synchronous to sys_clk
// and a core that reports instruction and bus-cycle completion.
`timescale 1ns/1ps
// Summary of operation
// - Low management interrupt level holds the core in protected handler mode.
// - Suspend waits for current instruction, decoded ones and their bus cycles.
// - Suspend request ignored after reset until the pin enable bit is set.
// - Acknowledge asserted once suspended, by request pin or by HALT.
// - Acknowledge floats after reset; driven only once pin enable is set.
// - Suspend stops core clocks only, or all clocks, as configured.
// - Serial packet output is a single wire timed by system clock.
// - Serial packets carry miscellaneous status for chipset handlers.
module ssh_suspend_smi
   import ssh_pkg::*;
#(
   parameter int DRAIN = DRAIN_CYCLES
)
(
   // Clock, reset, enable
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic clk_en,
   // Configuration (second control register bits)
   input  wire logic suspend_pin_enable,
   input  wire logic stop_all_clocks,
   // System pins
   input  wire logic mgmt_interrupt_n,
   input  wire logic suspend_request_n,
   input  wire logic clocks_running,
   // Core status
   input  wire logic halt_exec,
   input  wire logic core_idle,
   // Outputs
   output logic      protected_handler_mode,
   output logic      suspend_ack_n,
   output logic      suspend_ack_oe,
   output logic      core_clk_stop,
   output logic      all_clk_stop,
   output logic      serial_packet_out
);
   localparam int DW = $clog2(DRAIN + 1);

   // =========================================================
   // Registers
   ssh_state_t   state_ff, nxt_state;
   logic [DW-1:0] drain_ff, nxt_drain;
   logic         halt_src_ff;
   logic         smm_ff, ack_n_ff, oe_ff, cstop_ff, astop_ff;
   logic [PKT_DATA_W-1:0] last_st_ff;
   logic         tx_busy;

   // =========================================================
   // Decode
   // Request gating
   wire req_act   = suspend_pin_enable && !suspend_request_n;
   wire suspend_request_n_trig = req_act || halt_exec;
   // Drain done when counted out and core idle
   wire drained   = (drain_ff == '0) && core_idle;
   wire wake_ok   = halt_src_ff ? (!halt_exec || req_act) : !req_act;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_drain = drain_ff;
      case (state_ff)
         SSH_RUN:
            if (suspend_request_n_trig)
            begin
               nxt_state = SSH_DRAIN;
               nxt_drain = DW'(DRAIN);
            end
         SSH_DRAIN:
         begin
            if (drain_ff != '0)
               nxt_drain = drain_ff - DW'(1);
            if (drained)
               nxt_state = SSH_SUSPEND_REQUEST_N;
         end
         SSH_SUSPEND_REQUEST_N:
            if (wake_ok)
               nxt_state = SSH_RESUME;
         SSH_RESUME:
            if (clocks_running)
               nxt_state = SSH_RUN;
         default:
            nxt_state = SSH_RUN;
      endcase
   end

   wire in_suspend_request_n = (nxt_state == SSH_SUSPEND_REQUEST_N);

   wire [PKT_DATA_W-1:0] status_w = PKT_DATA_W'({stop_all_clocks, halt_src_ff,
                                                  in_suspend_request_n, !mgmt_interrupt_n});
   wire send_pkt = (status_w != last_st_ff) && !tx_busy;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff    <= SSH_RUN;
         drain_ff    <= '0;
         halt_src_ff <= 1'b0;
         smm_ff      <= 1'b0;
         ack_n_ff    <= 1'b1;
         oe_ff       <= PIN_EN_RST;
         cstop_ff    <= 1'b0;
         astop_ff    <= 1'b0;
         last_st_ff  <= '0;
      end
      else if (clk_en)
      begin
         state_ff <= nxt_state;
         drain_ff <= nxt_drain;
         if (state_ff == SSH_RUN)
            halt_src_ff <= halt_exec && !req_act;
         smm_ff   <= !mgmt_interrupt_n;
         ack_n_ff <= !in_suspend_request_n;
         oe_ff    <= suspend_pin_enable;
         cstop_ff <= in_suspend_request_n;
         astop_ff <= in_suspend_request_n && stop_all_clocks;
         if (send_pkt)
            last_st_ff <= status_w;
      end
   end

   assign protected_handler_mode = smm_ff;
   assign suspend_ack_n          = ack_n_ff;
   assign suspend_ack_oe         = oe_ff;
   assign core_clk_stop          = cstop_ff;
   assign all_clk_stop           = astop_ff;

   ssh_serial_tx #(.DATA_W(PKT_DATA_W)) u_tx (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .send    (send_pkt),
      .data    (status_w),
      .busy    (tx_busy),
      .ser_ff  (serial_packet_out)
   );

   // =========================================================
   // Checks
   sequence s_req_seen;
      clk_en && state_ff == SSH_RUN && suspend_request_n_trig;
   endsequence

   // Packet accepted by the transmitter while the clock is enabled
   sequence s_pkt_load;
      clk_en && send_pkt;
   endsequence

   a_oe_follows_cfg : assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en |=> suspend_ack_oe == $past(suspend_pin_enable))
      else $error("acknowledge enable does not follow configuration");
   a_pkt_on_change : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_pkt_load |=> tx_busy)
      else $error("status change not sent");
   // Start bit one edge after load
   a_pkt_start_bit : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_pkt_load ##1 clk_en |=> serial_packet_out == SER_START)
      else $error("packet start bit missing");
   // Core clocks stopped exactly while suspended
   a_cstop_in_suspend_request_n : assert property (@(posedge sys_clk) disable iff (!resetn)
      core_clk_stop == (state_ff == SSH_SUSPEND_REQUEST_N))
      else $error("core clock stop out of step with suspend");

   a_smm_follows_pin : assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en |=> protected_handler_mode == !$past(mgmt_interrupt_n))
      else $error("handler mode does not follow interrupt level");
   a_drain_before_ack : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_req_seen |=> suspend_ack_n)
      else $error("acknowledge before drain");
   a_req_ignored : assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && state_ff == SSH_RUN && !suspend_pin_enable && !halt_exec
      |=> state_ff == SSH_RUN)
      else $error("suspend taken while pin disabled");
   a_ack_in_suspend_request_n : assert property (@(posedge sys_clk) disable iff (!resetn)
      state_ff == SSH_SUSPEND_REQUEST_N |-> !suspend_ack_n)
      else $error("no acknowledge in suspend");
   a_ack_float : assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && !suspend_pin_enable |=> !suspend_ack_oe)
      else $error("acknowledge driven while disabled");
   a_allclk_sel : assert property (@(posedge sys_clk) disable iff (!resetn)
      all_clk_stop |-> core_clk_stop && $past(stop_all_clocks))
      else $error("all clocks stopped without selection");
   a_resume_ack : assert property (@(posedge sys_clk) disable iff (!resetn)
      state_ff == SSH_RESUME |-> suspend_ack_n && !core_clk_stop)
      else $error("acknowledge held after resume");
   a_drain_len : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_req_seen ##1 (clk_en && core_idle)[*5] |=> state_ff != SSH_DRAIN)
      else $error("drain did not finish");
endmodule : ssh_suspend_smi

//--- rtl/ssh_pkg.sv
// Constants for the suspend and management-interrupt handshake block.
// Assumes one system clock domain; no software-visible register map.
package ssh_pkg;
   // =========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   // Cycles the core needs to drain its pipeline and bus cycles
   localparam int DRAIN_CYCLES  = 4;
   // Idle bits shifted out after each stop bit, before the next packet can load
   localparam int PKT_GAP       = 2;
   // =========================================================
   // Packet layout: start bit, status bits, stop bit
   localparam int PKT_DATA_W    = 8;
   localparam logic SER_IDLE    = 1'b1;
   localparam logic SER_START   = 1'b0;
   // Status field positions inside a packet
   localparam int ST_SMM_BIT    = 0;
   localparam int ST_SUSPEND_REQUEST_N_BIT   = 1;
   localparam int ST_HALT_BIT   = 2;
   localparam int ST_ALLCLK_BIT = 3;
   // Configuration reset values
   localparam logic PIN_EN_RST  = 1'b0;
   // =========================================================
   // Suspend sequencer states
   typedef enum logic [2:0] {
      SSH_RUN    = 3'b000,
      SSH_DRAIN  = 3'b001,
      SSH_SUSPEND_REQUEST_N   = 3'b010,
      SSH_RESUME = 3'b011
   } ssh_state_t;
endpackage : ssh_pkg

//--- rtl/ssh_serial_tx.sv
// Single-wire status packet transmitter.
// Assumes send is a one-cycle pulse; it is dropped while busy is high.
`timescale 1ns/1ps
module ssh_serial_tx
   import ssh_pkg::*;
#(
   parameter int DATA_W = PKT_DATA_W
)
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   // Packet request
   input  wire logic              send,
   input  wire logic [DATA_W-1:0] data,
   output logic                   busy,
   // Serial wire
   output logic                   ser_ff
);
   localparam int FRAME = DATA_W + 2 + PKT_GAP;
   localparam int CW    = $clog2(FRAME + 1);

   logic [DATA_W+1:0] shift_ff;
   logic [CW-1:0]     cnt_ff;

   assign busy = (cnt_ff != '0);

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         shift_ff <= '1;
         cnt_ff   <= '0;
         ser_ff   <= 1'b1;
      end
      else if (clk_en)
      begin
         if (send && !busy)
         begin
            // Stop bit, data LSB first, start bit
            shift_ff <= {SER_IDLE, data, SER_START};
            cnt_ff   <= CW'(FRAME);
         end
         else if (busy)
         begin
            ser_ff   <= shift_ff[0];
            shift_ff <= {SER_IDLE, shift_ff[DATA_W+1:1]};
            cnt_ff   <= cnt_ff - CW'(1);
         end
         else
            ser_ff   <= SER_IDLE;
      end
   end

   a_ser_idle_level : assert property (@(posedge sys_clk) disable iff (!resetn)
      (cnt_ff == '0) && $past(cnt_ff == '0) && $past(clk_en) |-> ser_ff == SER_IDLE)
      else $error("serial wire not idle between packets");
endmodule : ssh_serial_tx

//--- tb/ssh_chipset_model.sv
// Companion chipset model: restarts stopped clocks, receives status packets.
// Assumes all block outputs timed by sys_clk.
`timescale 1ns/1ps
module ssh_chipset_model
   import ssh_pkg::*;
#(
   parameter int RESTART_DLY = 3
)
(
   // Clock and reset
   input  wire logic  sys_clk,
   input  wire logic  resetn,
   // From the block
   input  wire logic  core_clk_stop,
   input  wire logic  serial_packet_out,
   // To the block and bench
   output logic       clocks_running,
   output logic [7:0] last_pkt,
   output int         pkt_count
);
   int         restart_cnt;
   int         bit_idx;
   logic [7:0] shift;
   // ==========================================
   // Clock restart
   // clocks stay down while suspended and through the RESTART_DLY countdown after it
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clocks_running <= 1'b1;
         restart_cnt    <= 0;
      end
      else if (core_clk_stop)
      begin
         clocks_running <= 1'b0;
         restart_cnt    <= RESTART_DLY;
      end
      else if (restart_cnt > 0)
         restart_cnt <= restart_cnt - 1;
      else
         clocks_running <= 1'b1;
   end
   // ==========================================
   // Packet receiver, start bit then LSB first
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bit_idx   <= -1;
         pkt_count <= 0;
         last_pkt  <= 8'h00;
         shift     <= 8'h00;
      end
      else if (bit_idx < 0)
      begin
         if (serial_packet_out === SER_START)
            bit_idx <= 0;
      end
      else if (bit_idx < 8)
      begin
         shift[bit_idx] <= serial_packet_out;
         bit_idx        <= bit_idx + 1;
      end
      else
      begin
         // A bad stop bit drops the frame
         if (serial_packet_out === SER_IDLE)
         begin
            last_pkt  <= shift;
            pkt_count <= pkt_count + 1;
         end
         bit_idx <= -1;
      end
   end
endmodule : ssh_chipset_model

//--- tb/tb_ssh_suspend_smi.sv
// Self-checking bench for the suspend and management-interrupt block.
// Assumes the chipset model answers on the far side.
`timescale 1ns/1ps
module tb_ssh_suspend_smi
   import ssh_pkg::*;
;
   logic sys_clk, resetn, clk_en, suspend_pin_enable, stop_all_clocks;
   logic mgmt_interrupt_n, suspend_request_n, clocks_running, halt_exec, core_idle;
   logic protected_handler_mode, suspend_ack_n, suspend_ack_oe;
   logic core_clk_stop, all_clk_stop, serial_packet_out;
   logic [7:0] last_pkt;
   int         pkt_count, failures, num_checks, cycles;

   ssh_suspend_smi uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
      .suspend_pin_enable(suspend_pin_enable), .stop_all_clocks(stop_all_clocks),
      .mgmt_interrupt_n(mgmt_interrupt_n), .suspend_request_n(suspend_request_n),
      .clocks_running(clocks_running), .halt_exec(halt_exec), .core_idle(core_idle),
      .protected_handler_mode(protected_handler_mode), .suspend_ack_n(suspend_ack_n),
      .suspend_ack_oe(suspend_ack_oe), .core_clk_stop(core_clk_stop),
      .all_clk_stop(all_clk_stop), .serial_packet_out(serial_packet_out));
   ssh_chipset_model partner (.sys_clk(sys_clk), .resetn(resetn),
      .core_clk_stop(core_clk_stop), .serial_packet_out(serial_packet_out),
      .clocks_running(clocks_running), .last_pkt(last_pkt), .pkt_count(pkt_count));

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_ack(input logic lvl, input int max);
      int i;
      i = 0;
      while (suspend_ack_n !== lvl && i < max)
      begin
         tick(1);
         i++;
      end
      chk(suspend_ack_n, lvl);
   endtask : wait_ack
   task automatic conclude();
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // ==========================================
   // Scenarios
   task automatic t_smi();
      mgmt_interrupt_n = 1'b0;
      tick(1);
      chk(protected_handler_mode, 1'b1);
      tick(20);
      chk(last_pkt, 8'h01 << ST_SMM_BIT);
      mgmt_interrupt_n = 1'b1;
      tick(1);
      chk(protected_handler_mode, 1'b0);
      tick(20);
      chk(last_pkt, 8'h00);
   endtask : t_smi
   // Low enable must freeze the handler-mode flop
   task automatic t_freeze();
      clk_en = 1'b0;
      mgmt_interrupt_n = 1'b0;
      tick(3);
      chk(protected_handler_mode, 1'b0);
      clk_en = 1'b1;
      tick(1);
      chk(protected_handler_mode, 1'b1);
      mgmt_interrupt_n = 1'b1;
      tick(30);
      chk(last_pkt, 8'h00);
   endtask : t_freeze
   task automatic t_refuse();
      suspend_request_n = 1'b0;
      tick(12);
      chk({suspend_ack_n, core_clk_stop, suspend_ack_oe}, 8'h04);
      suspend_request_n = 1'b1;
      tick(2);
   endtask : t_refuse
   task automatic t_suspend_request_n(input logic sa);
      suspend_pin_enable = 1'b1;
      stop_all_clocks    = sa;
      core_idle          = 1'b0;
      tick(1);
      chk(suspend_ack_oe, 1'b1);
      suspend_request_n = 1'b0;
      tick(10);
      chk(suspend_ack_n, 1'b1);
      core_idle = 1'b1;
      wait_ack(1'b0, 10);
      chk({core_clk_stop, all_clk_stop}, {6'h00, 1'b1, sa});
      suspend_request_n = 1'b1;
      wait_ack(1'b1, 3);
      tick(25);
   endtask : t_suspend_request_n
   task automatic t_halt();
      stop_all_clocks = 1'b0;
      halt_exec       = 1'b1;
      wait_ack(1'b0, 10);
      tick(25);
      chk(last_pkt, (8'h01 << ST_HALT_BIT) | (8'h01 << ST_SUSPEND_REQUEST_N_BIT));
      halt_exec = 1'b0;
      wait_ack(1'b1, 3);
      tick(25);
   endtask : t_halt
   // ==========================================
   // Clock, timeout, main sequence
   initial
   begin
      sys_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   end
   // Whole run needs well under 1000 cycles
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         conclude();
      end
   end
   initial
   begin
      {failures, num_checks, cycles} = '0;
      resetn = 1'b0;
      clk_en = 1'b1;
      {suspend_pin_enable, stop_all_clocks, halt_exec, core_idle} = 4'h1;
      {mgmt_interrupt_n, suspend_request_n} = 2'h3;
      tick(3);
      resetn = 1'b1;
      tick(1);
      chk({protected_handler_mode, suspend_ack_n, suspend_ack_oe}, 8'h02);
      chk(serial_packet_out, SER_IDLE);
      t_smi();
      t_freeze();
      t_refuse();
      t_suspend_request_n(1'b0);
      t_suspend_request_n(1'b1);
      t_halt();
      conclude();
   end
endmodule : tb_ssh_suspend_smi
